// ===== common/vel_ramp_pkg.sv
// register map, field positions, reset values and types of the velocity
// ramp controller; shared by the design and the bench
package vel_ramp_pkg;
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_MODE = 8'h04;
    localparam logic [7:0] A_PROF = 8'h08;
    localparam logic [7:0] A_TGT = 8'h0C;
    localparam logic [7:0] A_VMIN = 8'h10;
    localparam logic [7:0] A_VMAX = 8'h14;
    localparam logic [7:0] A_MAXPV = 8'h18;
    localparam logic [7:0] A_MAXMS = 8'h1C;
    localparam logic [7:0] A_ACC = 8'h20;
    localparam logic [7:0] A_DEC = 8'h24;
    localparam logic [7:0] A_QSD = 8'h28;
    localparam logic [7:0] A_OFFS = 8'h2C;
    localparam logic [7:0] A_WIN = 8'h30;
    localparam logic [7:0] A_WTIME = 8'h34;
    localparam logic [7:0] A_THR = 8'h38;
    localparam logic [7:0] A_TTIME = 8'h3C;
    localparam logic [7:0] A_SLIP = 8'h40;
    localparam logic [7:0] A_STIME = 8'h44;
    localparam logic [7:0] A_ACT = 8'h48;
    localparam logic [7:0] A_POSLO = 8'h4C;
    localparam logic [7:0] A_POSHI = 8'h50;
    localparam logic [7:0] A_POSIN = 8'h54;
    localparam logic [7:0] A_POSW = 8'h58;
    localparam logic [7:0] A_DEM = 8'h5C;
    localparam logic [7:0] A_STAT = 8'h60;
    localparam logic [7:0] A_UNIT = 8'h64;
    localparam logic [7:0] A_USPD = 8'h68;
    localparam int unsigned B_HALT = 8;
    localparam int unsigned B_QSTOP = 0;
    localparam int unsigned B_CLOOP = 1;
    localparam int unsigned B_REACH = 10;
    localparam int unsigned B_LIMIT = 11;
    localparam int unsigned B_ZERO = 12;
    localparam int unsigned B_DEV = 13;
    localparam logic [7:0] MODE_VL = 8'h02;
    localparam logic [7:0] MODE_PV = 8'h03;
    localparam logic [7:0] PROF_TRAP = 8'h00;
    localparam logic [7:0] PROF_JERK = 8'h03;
    localparam logic [31:0] RST_VMAX = 32'h0000_0BB8;
    localparam logic [31:0] RST_ACC = 32'h0000_0064;
    localparam logic [31:0] RST_UNIT = 32'h0001_0001;
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
    typedef struct packed {
        logic [31:0] addr;
        logic wr;
        logic sel;
    } ahb_req_t;
    typedef struct packed {
        logic vl;
        logic pv;
        logic jerk;
    } mode_t;
endpackage : vel_ramp_pkg

// ===== verilog/vel_ramp_ctrl.sv
// velocity / profile velocity ramp controller with AHB-Lite registers
// assumes single-word AHB transfers; ramp runs at a 1 ms tick enable
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module vel_ramp_ctrl #(
    parameter int unsigned TICK = vel_ramp_pkg::TICK_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] demand_o,
    output logic [15:0] status_o
);
    logic [31:0] ctrl_q, mode_q, prof_q, tgt_q, vmin_q, vmax_q, maxpv_q;
    logic [31:0] maxms_q, acc_q, dec_q, qsd_q, offs_q, win_q, wtime_q;
    logic [31:0] thr_q, ttime_q, slip_q, stime_q, act_q, poslo_q, poshi_q;
    logic [31:0] posin_q, posw_q, unit_q, uspd_q;
    logic signed [31:0] dem_q;
    vel_ramp_pkg::ahb_req_t req_q;
    vel_ramp_pkg::mode_t md;
    logic [31:0] tick_cnt_q;
    logic tick;
    logic [31:0] wcnt_q, tcnt_q, scnt_q;
    logic reach_q, zero_q, dev_q, limit_q;
    logic [31:0] rd;

    // address phase registered; zero wait states
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_q <= '0;
        end else if (hready_i) begin
            req_q.addr <= haddr_i;
            req_q.wr <= hwrite_i;
            req_q.sel <= hsel_i & htrans_i[1];
        end
    end
    // every register answers in its data phase, so no wait states
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    wire wen = req_q.sel & req_q.wr;
    wire [7:0] wa = req_q.addr[7:0];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q <= '0; mode_q <= '0; prof_q <= '0; tgt_q <= '0;
            vmin_q <= '0; vmax_q <= vel_ramp_pkg::RST_VMAX;
            maxpv_q <= vel_ramp_pkg::RST_VMAX;
            maxms_q <= vel_ramp_pkg::RST_VMAX;
            acc_q <= vel_ramp_pkg::RST_ACC; dec_q <= vel_ramp_pkg::RST_ACC;
            qsd_q <= vel_ramp_pkg::RST_ACC; offs_q <= '0; win_q <= '0;
            wtime_q <= '0; thr_q <= '0; ttime_q <= '0; slip_q <= '0;
            stime_q <= '0; act_q <= '0; poslo_q <= '0; poshi_q <= '0;
            posin_q <= '0; unit_q <= vel_ramp_pkg::RST_UNIT;
        end else if (wen) begin
            unique case (wa)
                vel_ramp_pkg::A_CTRL: ctrl_q <= hwdata_i;
                vel_ramp_pkg::A_MODE: mode_q <= hwdata_i;
                vel_ramp_pkg::A_PROF: prof_q <= hwdata_i;
                vel_ramp_pkg::A_TGT: tgt_q <= hwdata_i;
                vel_ramp_pkg::A_VMIN: vmin_q <= hwdata_i;
                vel_ramp_pkg::A_VMAX: vmax_q <= hwdata_i;
                vel_ramp_pkg::A_MAXPV: maxpv_q <= hwdata_i;
                vel_ramp_pkg::A_MAXMS: maxms_q <= hwdata_i;
                vel_ramp_pkg::A_ACC: acc_q <= hwdata_i;
                vel_ramp_pkg::A_DEC: dec_q <= hwdata_i;
                vel_ramp_pkg::A_QSD: qsd_q <= hwdata_i;
                vel_ramp_pkg::A_OFFS: offs_q <= hwdata_i;
                vel_ramp_pkg::A_WIN: win_q <= hwdata_i;
                vel_ramp_pkg::A_WTIME: wtime_q <= hwdata_i;
                vel_ramp_pkg::A_THR: thr_q <= hwdata_i;
                vel_ramp_pkg::A_TTIME: ttime_q <= hwdata_i;
                vel_ramp_pkg::A_SLIP: slip_q <= hwdata_i;
                vel_ramp_pkg::A_STIME: stime_q <= hwdata_i;
                vel_ramp_pkg::A_ACT: act_q <= hwdata_i;
                vel_ramp_pkg::A_POSLO: poslo_q <= hwdata_i;
                vel_ramp_pkg::A_POSHI: poshi_q <= hwdata_i;
                vel_ramp_pkg::A_POSIN: posin_q <= hwdata_i;
                vel_ramp_pkg::A_UNIT: unit_q <= hwdata_i;
                default: ;
            endcase
        end
    end

    // two modes decoded, velocity and profile velocity; anything else ramps demand to zero
    always_comb begin
        md.vl = (mode_q[7:0] == vel_ramp_pkg::MODE_VL);
        md.pv = (mode_q[7:0] == vel_ramp_pkg::MODE_PV);
        // velocity mode never runs jerk-limited ramps
        md.jerk = md.pv & (prof_q[7:0] == vel_ramp_pkg::PROF_JERK);
    end

    // ramp tick divider
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_cnt_q <= '0;
        end else if (tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
        end
    end
    assign tick = (tick_cnt_q == TICK - 1);

    // set value: clamp target, then offset
    logic signed [31:0] tclamp, sp, lim, step, diff, acc_eff, dec_eff;
    logic signed [31:0] jstep;
    logic clamp_hit, rate_hit;
    always_comb begin
        tclamp = $signed(tgt_q);
        clamp_hit = 1'b0;
        if (md.vl && $signed(tgt_q) < $signed(vmin_q)) begin
            tclamp = $signed(vmin_q);
            clamp_hit = 1'b1;
        end
        if (md.vl && $signed(tgt_q) > $signed(vmax_q)) begin
            tclamp = $signed(vmax_q);
            clamp_hit = 1'b1;
        end
        sp = tclamp + $signed(offs_q);
        lim = ($signed(maxpv_q) < $signed(maxms_q)) ?
              $signed(maxpv_q) : $signed(maxms_q);
        if (sp > lim) begin
            sp = lim;
            clamp_hit = 1'b1;
        end
        if (sp < -lim) begin
            sp = -lim;
            clamp_hit = 1'b1;
        end
        // halt and quick stop both brake to standstill; no mode: demand to 0
        if (ctrl_q[vel_ramp_pkg::B_HALT] || !(md.vl || md.pv)) begin
            sp = '0;
        end
        if (ctrl_q[vel_ramp_pkg::B_QSTOP]) begin
            sp = '0;
        end
        // rate per tick: delta speed over delta time, time counted in ticks
        acc_eff = $signed({16'h0, acc_q[31:16]}) /
                  $signed({16'h0, (acc_q[15:0] == 16'h0) ? 16'h1
                           : acc_q[15:0]});
        dec_eff = $signed({16'h0, dec_q[31:16]}) /
                  $signed({16'h0, (dec_q[15:0] == 16'h0) ? 16'h1
                           : dec_q[15:0]});
        if (ctrl_q[vel_ramp_pkg::B_QSTOP]) begin
            dec_eff = $signed({16'h0, qsd_q[31:16]}) /
                      $signed({16'h0, (qsd_q[15:0] == 16'h0) ? 16'h1
                               : qsd_q[15:0]});
        end
        diff = sp - dem_q;
        // braking when demand falls from zero or above or rises from below zero, else accelerating
        if ((dem_q >= 0 && diff < 0) || (dem_q < 0 && diff > 0)) begin
            step = dec_eff;
        end else begin
            step = acc_eff;
        end
        // jerk-limited profile: half-rate step on every tick of the ramp
        // a rate of one stays one and a zero rate never moves the demand
        jstep = (step > 32'sh1) ? (step >>> 1) : step;
        if (md.jerk) begin
            step = jstep;
        end
        rate_hit = (diff > step) || (diff < -step);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dem_q <= '0;
        end else if (tick) begin
            if (diff > step) begin
                dem_q <= dem_q + step;
            end else if (diff < -step) begin
                dem_q <= dem_q - step;
            end else begin
                dem_q <= sp;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            limit_q <= 1'b0;
        end else begin
            limit_q <= md.vl & (clamp_hit | rate_hit);
        end
    end

    // speed window, threshold and slippage timers in ticks
    logic [31:0] verr, aabs, serr;
    always_comb begin
        verr = ($signed(act_q) > dem_q) ? act_q - dem_q : dem_q - act_q;
        aabs = act_q[31] ? -act_q : act_q;
        serr = verr;
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wcnt_q <= '0; tcnt_q <= '0; scnt_q <= '0;
            reach_q <= 1'b0; zero_q <= 1'b1; dev_q <= 1'b0;
        end else if (tick) begin
            if (verr <= win_q && dem_q == sp) begin
                if (wcnt_q >= wtime_q) begin
                    reach_q <= 1'b1;
                end else begin
                    wcnt_q <= wcnt_q + 32'h1;
                end
            end else begin
                wcnt_q <= '0;
                reach_q <= 1'b0;
            end
            if (aabs > thr_q) begin
                if (tcnt_q >= ttime_q) begin
                    zero_q <= 1'b0;
                end else begin
                    tcnt_q <= tcnt_q + 32'h1;
                end
            end else begin
                tcnt_q <= '0;
                zero_q <= 1'b1;
            end
            if (ctrl_q[vel_ramp_pkg::B_CLOOP] && serr > slip_q) begin
                if (scnt_q >= stime_q) begin
                    dev_q <= 1'b1;
                end else begin
                    scnt_q <= scnt_q + 32'h1;
                end
            end else begin
                scnt_q <= '0;
                dev_q <= 1'b0;
            end
        end
    end

    // status bits take their meaning from the active mode
    always_comb begin
        status_o = '0;
        if (md.vl) begin
            status_o[vel_ramp_pkg::B_LIMIT] = limit_q;
        end
        if (md.pv) begin
            // under halt: braking shows 0, demand and axis at rest show 1
            status_o[vel_ramp_pkg::B_REACH] =
                ctrl_q[vel_ramp_pkg::B_HALT] ? (dem_q == 0 && zero_q)
                : reach_q;
            status_o[vel_ramp_pkg::B_ZERO] = zero_q;
            // flag drops as soon as closed loop is left
            status_o[vel_ramp_pkg::B_DEV] =
                dev_q & ctrl_q[vel_ramp_pkg::B_CLOOP];
        end
    end
    assign demand_o = dem_q;

    // modulo wrap of an input position into the range limit pair
    logic [31:0] span, wrapped;
    always_comb begin
        span = poshi_q - poslo_q + 32'h1;
        wrapped = posin_q;
        if (span != 32'h0 && poshi_q > poslo_q) begin
            wrapped = poslo_q + (posin_q - poslo_q) % span;
            if ($signed(posin_q) < $signed(poslo_q)) begin
                wrapped = poshi_q - (poslo_q - posin_q - 32'h1) % span;
            end
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            posw_q <= '0;
            uspd_q <= '0;
        end else begin
            posw_q <= wrapped;
            // user units: internal speed times mul over div
            uspd_q <= 32'(($signed(64'(dem_q)) * $signed({16'h0,
                      unit_q[31:16]})) / $signed({16'h0,
                      (unit_q[15:0] == 16'h0) ? 16'h1
                      : unit_q[15:0]}));
        end
    end

    always_comb begin
        unique case (req_q.addr[7:0])
            vel_ramp_pkg::A_CTRL: rd = ctrl_q;
            vel_ramp_pkg::A_MODE: rd = mode_q;
            vel_ramp_pkg::A_PROF: rd = prof_q;
            vel_ramp_pkg::A_TGT: rd = tgt_q;
            vel_ramp_pkg::A_VMIN: rd = vmin_q;
            vel_ramp_pkg::A_VMAX: rd = vmax_q;
            vel_ramp_pkg::A_MAXPV: rd = maxpv_q;
            vel_ramp_pkg::A_MAXMS: rd = maxms_q;
            vel_ramp_pkg::A_ACC: rd = acc_q;
            vel_ramp_pkg::A_DEC: rd = dec_q;
            vel_ramp_pkg::A_QSD: rd = qsd_q;
            vel_ramp_pkg::A_OFFS: rd = offs_q;
            vel_ramp_pkg::A_WIN: rd = win_q;
            vel_ramp_pkg::A_WTIME: rd = wtime_q;
            vel_ramp_pkg::A_THR: rd = thr_q;
            vel_ramp_pkg::A_TTIME: rd = ttime_q;
            vel_ramp_pkg::A_SLIP: rd = slip_q;
            vel_ramp_pkg::A_STIME: rd = stime_q;
            vel_ramp_pkg::A_ACT: rd = act_q;
            vel_ramp_pkg::A_POSLO: rd = poslo_q;
            vel_ramp_pkg::A_POSHI: rd = poshi_q;
            vel_ramp_pkg::A_POSIN: rd = posin_q;
            vel_ramp_pkg::A_POSW: rd = posw_q;
            vel_ramp_pkg::A_DEM: rd = dem_q;
            vel_ramp_pkg::A_STAT: rd = {16'h0, status_o};
            vel_ramp_pkg::A_UNIT: rd = unit_q;
            vel_ramp_pkg::A_USPD: rd = uspd_q;
            default: rd = 32'h0;
        endcase
    end
    assign hrdata_o = (req_q.sel & ~req_q.wr) ? rd : 32'h0;
endmodule : vel_ramp_ctrl

// ===== testbench/vel_ramp_monitor.sv
// checker for the velocity ramp controller, bound to its top module
// assumes zero-wait AHB-Lite writes; mirrors control and mode registers
`timescale 1ns/1ps
module vel_ramp_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] demand_o,
    input wire logic [15:0] status_o
);
    logic wr_q;
    logic [7:0] wa_q;
    logic [15:0] ctrl_q;
    logic [7:0] mode_q;
    logic [31:0] prev_q;
    logic [31:0] mag;
    logic signed [31:0] dif;
    logic halt;
    logic qstop;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    assign dif = $signed(demand_o) - $signed(prev_q);
    assign mag = demand_o[31] ? 32'h0 - demand_o : demand_o;
    assign halt = ctrl_q[vel_ramp_pkg::B_HALT];
    assign qstop = ctrl_q[vel_ramp_pkg::B_QSTOP];
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_q <= 1'b0;
            wa_q <= 8'h00;
        end else if (hready_i) begin
            wr_q <= hsel_i && htrans_i[1] && hwrite_i;
            wa_q <= haddr_i[7:0];
        end
    end
    // mirror only what the status relations depend on
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q <= 16'h0000;
            mode_q <= 8'h00;
        end else if (wr_q && hready_i) begin
            if (wa_q == vel_ramp_pkg::A_CTRL) ctrl_q <= hwdata_i[15:0];
            if (wa_q == vel_ramp_pkg::A_MODE) mode_q <= hwdata_i[7:0];
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) prev_q <= 32'h0;
        else prev_q <= demand_o;
    end
    // bench never programs a step above 100 per tick
    a_step_bound: assert property (
        dif >= -32'sd100 && dif <= 32'sd100)
        else $error("demand step larger than ramp rate");
    a_halt_brake: assert property (
        halt && $past(halt) |-> mag <= $past(mag))
        else $error("demand grows while halted");
    a_halt_hold: assert property (
        halt && demand_o == 32'h0 |=> demand_o == 32'h0 || !halt)
        else $error("motor leaves standstill under halt");
    a_halt_zero: assert property (
        mode_q == vel_ramp_pkg::MODE_PV && halt && demand_o == 32'h0
        |-> status_o[vel_ramp_pkg::B_REACH] == status_o[vel_ramp_pkg::B_ZERO])
        else $error("standstill under halt not reported");
    a_halt_moving: assert property (
        mode_q == vel_ramp_pkg::MODE_PV && halt && demand_o != 32'h0
        |-> !status_o[vel_ramp_pkg::B_REACH])
        else $error("braking axis reported as reached");
    a_qstop_brake: assert property (
        qstop && $past(qstop) |-> mag <= $past(mag))
        else $error("demand grows during quick stop");
    a_open_loop: assert property (
        !ctrl_q[vel_ramp_pkg::B_CLOOP] |-> !status_o[vel_ramp_pkg::B_DEV])
        else $error("deviation flag outside closed loop");
    a_mode_bits: assert property (
        mode_q != vel_ramp_pkg::MODE_PV |-> !status_o[vel_ramp_pkg::B_REACH]
        && !status_o[vel_ramp_pkg::B_ZERO])
        else $error("profile status bit outside profile mode");
    a_limit_mode: assert property (
        mode_q != vel_ramp_pkg::MODE_VL |-> !status_o[vel_ramp_pkg::B_LIMIT])
        else $error("limit flag outside velocity mode");
    c_vl_limit: cover property (status_o[vel_ramp_pkg::B_LIMIT]);
    c_pv_reach: cover property (status_o[vel_ramp_pkg::B_REACH] && !halt);
    c_slip: cover property (status_o[vel_ramp_pkg::B_DEV]);
endmodule : vel_ramp_monitor
bind vel_ramp_ctrl vel_ramp_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
    .demand_o(demand_o), .status_o(status_o));

// ===== testbench/ahb_host_model.sv
// controlling program as an AHB-Lite master doing single word transfers
// assumes one slave whose hreadyout is fed back as hready
`timescale 1ns/1ps
module ahb_host_model (
    input wire logic clk_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i,
    output logic hsel_o,
    output logic [31:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [2:0] hsize_o,
    output logic [31:0] hwdata_o
);
    initial begin
        hsel_o = 1'b0;
        haddr_o = 32'h0;
        htrans_o = 2'b00;
        hwrite_o = 1'b0;
        hsize_o = 3'h2;
        hwdata_o = 32'h0;
    end
    // waits on hready without assuming a latency
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        hsel_o <= 1'b1;
        haddr_o <= {24'h0, a};
        htrans_o <= 2'b10;
        hwrite_o <= w;
        hsize_o <= 3'h2;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        htrans_o <= 2'b00;
        hwdata_o <= w ? d : ~hwdata_o;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        q = hrdata_i;
    endtask : xfer
endmodule : ahb_host_model

// ===== testbench/tb_velocity_mode_ramp_control.sv
// self-checking bench for the velocity ramp controller
// assumes a 10-cycle ramp tick; one register write per host transfer
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %s exp %0h got %0h", n, (e), (g)); end end
module tb_velocity_mode_ramp_control;
    localparam int unsigned TK = 10;
    localparam logic [31:0] R50 = 32'h0032_0001;
    localparam logic [31:0] R100 = 32'h0064_0001;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hsel, hwrite, hready, hresp;
    logic [31:0] haddr, hwdata, hrdata, demand;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] status;
    logic [31:0] v;
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    always #4 clk_i = ~clk_i;
    vel_ramp_ctrl #(.TICK(TK)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp), .demand_o(demand), .status_o(status));
    ahb_host_model u_host (.clk_i(clk_i), .hready_i(hready),
        .hrdata_i(hrdata), .hsel_o(hsel), .haddr_o(haddr),
        .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
        .hwdata_o(hwdata));
    task automatic end_of_test();
        if (failures == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        u_host.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        u_host.xfer(1'b0, a, 32'h0, q);
    endtask : rd
    task automatic settle();
        repeat (400) @(posedge clk_i);
    endtask : settle
    // any window of one tick length holds exactly one ramp update
    task automatic dstep(output logic [31:0] s);
        logic [31:0] p;
        @(posedge clk_i);
        p = demand;
        repeat (TK) @(posedge clk_i);
        s = demand - p;
    endtask : dstep
    task automatic t_reset();
        `CHK("demand", 32'h0, demand)
        `CHK("status", 16'h0, status)
        rd(vel_ramp_pkg::A_VMAX, v);
        `CHK("vmax", vel_ramp_pkg::RST_VMAX, v)
        rd(vel_ramp_pkg::A_ACC, v);
        `CHK("acc", vel_ramp_pkg::RST_ACC, v)
        rd(vel_ramp_pkg::A_UNIT, v);
        `CHK("unit", vel_ramp_pkg::RST_UNIT, v)
        rd(8'h80, v);
        `CHK("unmapped", 32'h0, v)
        `CHK("hresp", 1'b0, hresp)
    endtask : t_reset
    task automatic t_vl();
        wr(vel_ramp_pkg::A_ACC, R50);
        wr(vel_ramp_pkg::A_DEC, R50);
        wr(vel_ramp_pkg::A_QSD, R100);
        wr(vel_ramp_pkg::A_PROF, {24'h0, vel_ramp_pkg::PROF_JERK});
        wr(vel_ramp_pkg::A_VMIN, 32'd100);
        wr(vel_ramp_pkg::A_VMAX, 32'd500);
        wr(vel_ramp_pkg::A_TGT, 32'd1000);
        wr(vel_ramp_pkg::A_MODE, {24'h0, vel_ramp_pkg::MODE_VL});
        dstep(v);
        `CHK("vl step", 32'd50, v)
        settle();
        `CHK("vl max", 32'd500, demand)
        `CHK("vl limit", 1'b1, status[vel_ramp_pkg::B_LIMIT])
        wr(vel_ramp_pkg::A_TGT, 32'd20);
        settle();
        `CHK("vl min", 32'd100, demand)
        wr(vel_ramp_pkg::A_TGT, 32'd200);
        wr(vel_ramp_pkg::A_OFFS, 32'd7);
        settle();
        `CHK("vl offs", 32'd207, demand)
        `CHK("vl free", 1'b0, status[vel_ramp_pkg::B_LIMIT])
        wr(vel_ramp_pkg::A_OFFS, 32'd0);
    endtask : t_vl
    task automatic t_vl_halt();
        wr(vel_ramp_pkg::A_CTRL, 32'h100);
        dstep(v);
        `CHK("halt step", 32'hFFFF_FFCE, v)
        settle();
        `CHK("halt stop", 32'h0, demand)
        wr(vel_ramp_pkg::A_CTRL, 32'h0);
        dstep(v);
        `CHK("run step", 32'd50, v)
        settle();
        `CHK("run", 32'd200, demand)
    endtask : t_vl_halt
    task automatic t_pv();
        wr(vel_ramp_pkg::A_PROF, {24'h0, vel_ramp_pkg::PROF_TRAP});
        wr(vel_ramp_pkg::A_MAXPV, 32'd400);
        wr(vel_ramp_pkg::A_MAXMS, 32'd300);
        wr(vel_ramp_pkg::A_TGT, 32'd1000);
        wr(vel_ramp_pkg::A_MODE, {24'h0, vel_ramp_pkg::MODE_PV});
        settle();
        `CHK("pv cap", 32'd300, demand)
        wr(vel_ramp_pkg::A_TGT, 32'd20);
        settle();
        `CHK("pv no min", 32'd20, demand)
        wr(vel_ramp_pkg::A_PROF, {24'h0, vel_ramp_pkg::PROF_JERK});
        wr(vel_ramp_pkg::A_TGT, 32'd300);
        dstep(v);
        `CHK("jerk step", 32'd25, v)
        wr(vel_ramp_pkg::A_PROF, {24'h0, vel_ramp_pkg::PROF_TRAP});
        dstep(v);
        `CHK("trap step", 32'd50, v)
        wr(vel_ramp_pkg::A_TGT, 32'd300);
        settle();
    endtask : t_pv
    task automatic t_pv_status();
        wr(vel_ramp_pkg::A_WIN, 32'd10);
        wr(vel_ramp_pkg::A_WTIME, 32'd2);
        wr(vel_ramp_pkg::A_THR, 32'd50);
        wr(vel_ramp_pkg::A_TTIME, 32'd2);
        wr(vel_ramp_pkg::A_ACT, 32'd300);
        `CHK("reach early", 1'b0, status[vel_ramp_pkg::B_REACH])
        repeat (5 * TK) @(posedge clk_i);
        `CHK("reach", 1'b1, status[vel_ramp_pkg::B_REACH])
        `CHK("moving", 1'b0, status[vel_ramp_pkg::B_ZERO])
        wr(vel_ramp_pkg::A_CTRL, 32'h100);
        @(posedge clk_i);
        `CHK("braking", 1'b0, status[vel_ramp_pkg::B_REACH])
        settle();
        `CHK("pv halt", 32'h0, demand)
        `CHK("axis turning", 1'b0, status[vel_ramp_pkg::B_REACH])
        wr(vel_ramp_pkg::A_ACT, 32'd0);
        settle();
        `CHK("zero", 1'b1, status[vel_ramp_pkg::B_ZERO])
        `CHK("stand", 1'b1, status[vel_ramp_pkg::B_REACH])
        wr(vel_ramp_pkg::A_CTRL, 32'h0);
        settle();
        `CHK("pv run", 32'd300, demand)
    endtask : t_pv_status
    task automatic t_slip();
        wr(vel_ramp_pkg::A_UNIT, 32'h003C_0001);
        rd(vel_ramp_pkg::A_USPD, v);
        `CHK("user speed", 32'd18000, v)
        wr(vel_ramp_pkg::A_SLIP, 32'd10);
        wr(vel_ramp_pkg::A_STIME, 32'd2);
        wr(vel_ramp_pkg::A_CTRL, 32'h2);
        settle();
        `CHK("slip", 1'b1, status[vel_ramp_pkg::B_DEV])
        wr(vel_ramp_pkg::A_CTRL, 32'h0);
        @(posedge clk_i);
        `CHK("open loop", 1'b0, status[vel_ramp_pkg::B_DEV])
    endtask : t_slip
    task automatic t_wrap();
        wr(vel_ramp_pkg::A_POSLO, 32'd0);
        wr(vel_ramp_pkg::A_POSHI, 32'd99);
        wr(vel_ramp_pkg::A_POSIN, 32'd250);
        rd(vel_ramp_pkg::A_POSW, v);
        `CHK("wrap up", 32'd50, v)
        wr(vel_ramp_pkg::A_POSIN, 32'hFFFF_FFE2);
        rd(vel_ramp_pkg::A_POSW, v);
        `CHK("wrap down", 32'd70, v)
    endtask : t_wrap
    task automatic t_qstop();
        wr(vel_ramp_pkg::A_CTRL, 32'h1);
        dstep(v);
        `CHK("qs step", 32'hFFFF_FF9C, v)
        settle();
        `CHK("qs stop", 32'h0, demand)
        wr(vel_ramp_pkg::A_CTRL, 32'h0);
        wr(vel_ramp_pkg::A_MODE, 32'h0);
        settle();
        `CHK("no mode", 32'h0, demand)
        `CHK("no bits", 3'h0, status[12:10])
    endtask : t_qstop
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_wrap();
        t_vl();
        t_vl_halt();
        t_pv();
        t_pv_status();
        t_slip();
        t_qstop();
        end_of_test();
    end
endmodule : tb_velocity_mode_ramp_control
